// ==== hdl/dsf_pkg.sv ====
// shared constants of the integrity status and cache flush engine
package dsf_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OPFL = 8'h04;
  localparam logic [7:0] A_DSTL = 8'h08;
  localparam logic [7:0] A_DSTH = 8'h0C;
  localparam logic [7:0] A_SIZE = 8'h10;
  localparam logic [7:0] A_DIFC = 8'h14;
  localparam logic [7:0] A_APP  = 8'h18;
  localparam logic [7:0] A_REF  = 8'h1C;
  localparam logic [7:0] A_GRD  = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_ISR  = 8'h28;
  localparam logic [7:0] A_IMR  = 8'h2C;
  localparam logic [7:0] A_CR0  = 8'h30;
  localparam logic [7:0] A_CR1  = 8'h34;
  localparam logic [7:0] A_CR2  = 8'h38;
  localparam logic [7:0] A_CR3  = 8'h3C;
  // reset values
  localparam logic [31:0] RST_W = 32'h0000_0000;
  localparam logic [2:0]  RST_I = 3'h0;
  // operation codes and main status codes
  localparam logic [7:0] OP_FLUSH  = 8'h20;
  localparam logic [7:0] OP_CHECK  = 8'h30;
  localparam logic [7:0] OP_STRIP  = 8'h31;
  localparam logic [7:0] OP_UPDATE = 8'h32;
  localparam logic [7:0] ST_OK     = 8'h01;
  localparam logic [7:0] ST_DIFERR = 8'h02;
  localparam logic [7:0] ST_BADOP  = 8'h03;
  localparam logic [7:0] ST_FAULT  = 8'h04;
  // field positions
  localparam int CT_GO   = 0;
  localparam int FL_CC   = 8;
  localparam int FB_ATRF = 3;
  localparam int FB_APPF = 2;
  localparam int FB_ALLF = 1;
  localparam int FB_ALLE = 0;
  localparam int DC_GDIS = 8;
  localparam int DC_RDIS = 9;
  localparam int DC_GMIS = 10;
  localparam int DC_AMIS = 11;
  localparam int DC_RMIS = 12;
  localparam int IB_FL   = 0;
  localparam int IB_DIF  = 1;
  localparam int IB_ERR  = 2;
  // cache line geometry
  localparam int          CL_SHIFT = 6;
  localparam logic [63:0] LINE_B   = 64'h0000_0000_0000_0040;
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ISSUE = 3'b001,
    S_WAIT  = 3'b010,
    S_DIF   = 3'b011,
    S_DONE  = 3'b100
  } dsf_state_t;
endpackage

// ==== hdl/dsf_dif_status.sv ====
// integrity status byte from source tags, flags and compare results
`timescale 1ns/100ps
`default_nettype none
module dsf_dif_status
  import dsf_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // source integrity inputs
  input  wire logic [7:0]  flags,
  input  wire logic        gdis,
  input  wire logic        rdis,
  input  wire logic        gmis,
  input  wire logic        amis,
  input  wire logic        rmis,
  input  wire logic [15:0] amask,
  input  wire logic [15:0] atag,
  input  wire logic [31:0] rtag,
  input  wire logic [15:0] grd,
  // status byte
  output logic      [7:0]  st_r
);
  logic allf;
  logic esc;
  logic [7:0] st_nxt;
  assign allf = &atag && &rtag && &grd;
  assign esc = (flags[FB_ALLF] && allf) || (flags[FB_APPF] && &atag)
            || (flags[FB_ATRF] && &atag && &rtag);
  always_comb begin
    st_nxt = 8'h00;
    st_nxt[0] = !gdis && !esc && gmis;
    st_nxt[1] = (amask != 16'hFFFF) && !esc && amis;
    st_nxt[2] = !rdis && !esc && rmis;
    st_nxt[3] = flags[FB_ALLF] && flags[FB_ALLE] && allf;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= 8'h00;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_comb;
    ce && gmis && amis && rmis && !gdis && !rdis && amask != 16'hFFFF
      && flags[3:1] == 3'h0 |=> st_r[2:0] == 3'h7;
  endproperty
  a_comb: assert property (p_comb)
    else $error("mismatch codes not combined");
  property p_grd;
    ce && gdis |=> !st_r[0];
  endproperty
  a_grd: assert property (p_grd)
    else $error("guard code while disabled");
  property p_app;
    ce && amask == 16'hFFFF |=> !st_r[1];
  endproperty
  a_app: assert property (p_app)
    else $error("app code with full mask");
  property p_ref;
    ce && !rdis && rmis && flags[3:1] == 3'h0 |=> st_r[2];
  endproperty
  a_ref: assert property (p_ref)
    else $error("ref code missing");
  property p_allf;
    ce && flags[FB_ALLF] && flags[FB_ALLE] && allf |=> st_r[3];
  endproperty
  a_allf: assert property (p_allf)
    else $error("all ones error missing");
  property p_esc;
    ce && flags[FB_APPF] && &atag |=> st_r[2:0] == 3'h0;
  endproperty
  a_esc: assert property (p_esc)
    else $error("escape did not suppress checks");
endmodule
`default_nettype wire

// ==== hdl/dsf_line_walk.sv ====
// walks the cache lines covered by a byte range
`timescale 1ns/100ps
`default_nettype none
module dsf_line_walk
  import dsf_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // control
  input  wire logic        load,
  input  wire logic        step,
  input  wire logic [63:0] dst,
  input  wire logic [31:0] size,
  // position
  output logic      [63:0] cur_r,
  output logic             last
);
  logic [63:0] end_r;
  logic [63:0] end_nxt;
  assign end_nxt = dst + {32'h0, size} - 64'h1;
  assign last = cur_r[63:CL_SHIFT] == end_r[63:CL_SHIFT];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_r <= 64'h0;
      end_r <= 64'h0;
    end else if (ce) begin
      if (load) begin
        cur_r <= {dst[63:CL_SHIFT], {CL_SHIFT{1'b0}}};
        end_r <= end_nxt;
      end else if (step) begin
        cur_r <= cur_r + LINE_B;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/dsf_engine.sv ====
// register front end, flush sequencer and completion record
// Operation
// - The integrity status sits in byte 1 of the completion record.
// - That byte carries codes only for integrity ops with integrity error.
// - Guard, app and ref mismatch codes combine as one bit set.
// - Code 0x01 when guard check on, no escape and guard differs.
// - Code 0x02 when app mask not all ones, no escape and app tag differs.
// - Code 0x04 when ref check on, no escape and ref compare fails.
// - Code 0x08 when all-ones detect and its error are on and all are ones.
// - Escape holds under all-ones, app-only or app-and-ref detection.
// - Escape enables are source flag bits 3, 2 and 1.
// - Operation 0x20 flushes the range at destination for size bytes.
// - Any alignment and length; every touched line is flushed.
// - Cache control 0 invalidates lines everywhere after write back.
// - Cache control 1 writes back modified lines and keeps them.
`timescale 1ns/100ps
`default_nettype none
module dsf_engine
  import dsf_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // cache maintenance port
  output logic             fl_req,
  output logic      [63:0] fl_addr,
  output logic             fl_keep,
  input  wire logic        fl_ack,
  input  wire logic        fl_err,
  // completion and interrupt
  output logic             cr_valid,
  output logic             irq
);
  dsf_state_t  state_r;
  logic [31:0] opfl_r;
  logic [31:0] dstl_r;
  logic [31:0] dsth_r;
  logic [31:0] size_r;
  logic [31:0] difc_r;
  logic [31:0] app_r;
  logic [31:0] ref_r;
  logic [15:0] grd_r;
  logic [2:0]  isr_r;
  logic [2:0]  isr_nxt;
  logic [2:0]  imr_r;
  logic [31:0] cr0_r;
  logic [31:0] cr1_r;
  logic [31:0] cr2_r;
  logic [31:0] cr3_r;
  logic [7:0]  dif_st;
  logic [63:0] line_cur;
  logic        line_last;
  logic [63:0] dst;
  logic [63:0] dst_al;
  logic [63:0] span;
  logic [31:0] part;
  logic        wr_cfg;
  logic        start;
  logic        is_fl;
  logic        is_dif;
  logic        ack_ok;
  logic        ack_bad;
  logic [2:0]  ev;
  logic [2:0]  w1c;

  assign dst    = {dsth_r, dstl_r};
  assign dst_al = {dst[63:CL_SHIFT], {CL_SHIFT{1'b0}}};
  assign is_fl  = opfl_r[31:24] == OP_FLUSH;
  assign is_dif = opfl_r[31:24] == OP_CHECK
               || opfl_r[31:24] == OP_STRIP
               || opfl_r[31:24] == OP_UPDATE;
  // descriptor fields are locked while busy
  assign wr_cfg = ce && reg_wr && state_r == S_IDLE;
  assign start  = wr_cfg && reg_addr == A_CTRL && reg_wdata[CT_GO];
  assign ack_ok  = state_r == S_WAIT && fl_ack && !fl_err;
  assign ack_bad = state_r == S_WAIT && fl_ack && fl_err;
  // bytes of the range finished once this line is done
  assign span = fl_addr + LINE_B - dst;
  assign part = (span[63:32] != 32'h0 || span[31:0] > size_r)
              ? size_r : span[31:0];

  // descriptor and integrity input registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      opfl_r <= RST_W;
      dstl_r <= RST_W;
      dsth_r <= RST_W;
      size_r <= RST_W;
      difc_r <= RST_W;
      app_r  <= RST_W;
      ref_r  <= RST_W;
      grd_r  <= RST_W[15:0];
    end else if (wr_cfg) begin
      case (reg_addr)
        A_OPFL: opfl_r <= reg_wdata;
        A_DSTL: dstl_r <= reg_wdata;
        A_DSTH: dsth_r <= reg_wdata;
        A_SIZE: size_r <= reg_wdata;
        A_DIFC: difc_r <= reg_wdata;
        A_APP:  app_r  <= reg_wdata;
        A_REF:  ref_r  <= reg_wdata;
        A_GRD:  grd_r  <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // status byte former
  // escape flag bits
  dsf_dif_status u_dif (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .flags   (difc_r[7:0]),
    .gdis    (difc_r[DC_GDIS]),
    .rdis    (difc_r[DC_RDIS]),
    .gmis    (difc_r[DC_GMIS]),
    .amis    (difc_r[DC_AMIS]),
    .rmis    (difc_r[DC_RMIS]),
    .amask   (app_r[15:0]),
    .atag    (app_r[31:16]),
    .rtag    (ref_r),
    .grd     (grd_r),
    .st_r    (dif_st)
  );

  // line walker
  dsf_line_walk u_walk (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .load    (start && is_fl),
    .step    (ack_ok && !line_last),
    .dst     (dst),
    .size    (size_r),
    .cur_r   (line_cur),
    .last    (line_last)
  );

  // operation sequencer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= S_IDLE;
    end else if (ce) begin
      unique case (state_r)
        S_IDLE: begin
          if (start && is_fl && size_r != RST_W) begin
            state_r <= S_ISSUE;
          end else if (start && is_dif) begin
            state_r <= S_DIF;
          end else if (start) begin
            state_r <= S_DONE;
          end
        end
        S_ISSUE: begin
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (ack_bad || (ack_ok && line_last)) begin
            state_r <= S_DONE;
          end else if (ack_ok) begin
            state_r <= S_ISSUE;
          end
        end
        S_DIF: begin
          state_r <= S_DONE;
        end
        S_DONE: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // cache maintenance requests
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fl_req  <= 1'b0;
      fl_addr <= 64'h0;
      fl_keep <= 1'b0;
    end else if (ce) begin
      if (state_r == S_ISSUE) begin
        fl_req  <= 1'b1;
        fl_addr <= line_cur;
        fl_keep <= opfl_r[FL_CC];
      end else if (state_r == S_WAIT && fl_ack) begin
        fl_req <= 1'b0;
      end
    end
  end

  // completion record
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cr0_r    <= RST_W;
      cr1_r    <= RST_W;
      cr2_r    <= RST_W;
      cr3_r    <= RST_W;
      cr_valid <= 1'b0;
    end else if (ce) begin
      cr_valid <= state_r == S_DONE;
      if (start) begin
        cr0_r <= {24'h0, (is_fl || is_dif) ? ST_OK : ST_BADOP};
        cr1_r <= RST_W;
        cr2_r <= RST_W;
        cr3_r <= RST_W;
      end
      if (ack_ok) begin
        cr1_r <= part;
      end
      if (ack_bad) begin
        cr0_r[7:0] <= ST_FAULT;
        cr2_r      <= fl_addr[31:0];
        cr3_r      <= fl_addr[63:32];
      end
      if (state_r == S_DIF) begin
        if (dif_st != 8'h00) begin
          cr0_r[7:0]  <= ST_DIFERR;
          cr0_r[15:8] <= dif_st;
        end else begin
          cr0_r[7:0]  <= ST_OK;
          cr0_r[15:8] <= 8'h00;
        end
      end
    end
  end

  // sticky events, set beats clear
  assign ev[IB_FL]  = state_r == S_DONE && is_fl && cr0_r[7:0] == ST_OK;
  assign ev[IB_DIF] = state_r == S_DONE && is_dif;
  assign ev[IB_ERR] = state_r == S_DONE && cr0_r[7:0] != ST_OK;
  assign w1c = (reg_wr && reg_addr == A_ISR) ? reg_wdata[2:0] : RST_I;
  assign isr_nxt = ev | (isr_r & ~w1c);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      isr_r <= RST_I;
      imr_r <= RST_I;
      irq   <= 1'b0;
    end else if (ce) begin
      isr_r <= isr_nxt;
      if (reg_wr && reg_addr == A_IMR) begin
        imr_r <= reg_wdata[2:0];
      end
      irq <= |(isr_r & imr_r);
    end
  end

  // read port, data valid the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= RST_W;
    end else if (ce) begin
      reg_rdata <= RST_W;
      if (reg_rd) begin
        case (reg_addr)
          A_OPFL: reg_rdata <= opfl_r;
          A_DSTL: reg_rdata <= dstl_r;
          A_DSTH: reg_rdata <= dsth_r;
          A_SIZE: reg_rdata <= size_r;
          A_DIFC: reg_rdata <= difc_r;
          A_APP:  reg_rdata <= app_r;
          A_REF:  reg_rdata <= ref_r;
          A_GRD:  reg_rdata <= {16'h0, grd_r};
          A_STAT: reg_rdata <= {16'h0, dif_st, 7'h0, state_r != S_IDLE};
          A_ISR:  reg_rdata <= {29'h0, isr_r};
          A_IMR:  reg_rdata <= {29'h0, imr_r};
          A_CR0:  reg_rdata <= cr0_r;
          A_CR1:  reg_rdata <= cr1_r;
          A_CR2:  reg_rdata <= cr2_r;
          A_CR3:  reg_rdata <= cr3_r;
          default: reg_rdata <= RST_W;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_fl_go;
    start && is_fl && size_r != 32'h0 ##1 ce;
  endsequence

  sequence s_dif_err;
    state_r == S_DIF && ce && dif_st != 8'h00;
  endsequence

  property p_fl_go;
    s_fl_go |=> fl_req;
  endproperty
  a_fl_go: assert property (p_fl_go)
    else $error("flush request not raised");

  property p_fl_first;
    s_fl_go |=> fl_addr == $past(dst_al, 2);
  endproperty
  a_fl_first: assert property (p_fl_first)
    else $error("first flush line not aligned start");

  property p_inval;
    fl_req && !opfl_r[FL_CC] |-> !fl_keep;
  endproperty
  a_inval: assert property (p_inval)
    else $error("invalidate flush marked keep");

  property p_keep;
    fl_req && opfl_r[FL_CC] |-> fl_keep;
  endproperty
  a_keep: assert property (p_keep)
    else $error("write back flush not marked keep");

  property p_full;
    ack_ok && line_last && ce |=> cr1_r == size_r && state_r == S_DONE;
  endproperty
  a_full: assert property (p_full)
    else $error("bytes completed short of size");

  property p_fault;
    ack_bad && ce |=> cr0_r[7:0] == ST_FAULT
      && {cr3_r, cr2_r} == $past(fl_addr);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault record wrong");

  property p_dif_pos;
    s_dif_err |=> cr0_r[15:8] == $past(dif_st) ##1 cr_valid;
  endproperty
  a_dif_pos: assert property (p_dif_pos)
    else $error("integrity byte not in byte 1");

  property p_dif_only;
    cr_valid && cr0_r[7:0] != ST_DIFERR |-> cr0_r[15:8] == 8'h00;
  endproperty
  a_dif_only: assert property (p_dif_only)
    else $error("integrity byte set without integrity error");
endmodule
`default_nettype wire

// ==== verification/dsf_cache_model.sv ====
// cache maintenance responder on the flush link
`timescale 1ns/100ps
`default_nettype none
module dsf_cache_model (
  // clock
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // flush link
  input  wire logic       fl_req,
  output logic            fl_ack,
  output logic            fl_err,
  // behaviour
  input  wire logic [3:0] delay,
  input  wire logic [7:0] fail_idx,
  input  wire logic       restart
);
  logic [3:0] cnt_r;
  logic [7:0] n_r;
  always @(posedge ref_clk) begin
    fl_ack <= 1'b0;
    // fault flag is meaningless outside an ack
    fl_err <= ~fl_err;
    if (srst || restart) begin
      fl_err <= 1'b0;
      cnt_r  <= 4'h0;
      n_r    <= 8'h00;
    end else if (fl_req && !fl_ack) begin
      if (cnt_r >= delay) begin
        fl_ack <= 1'b1;
        fl_err <= (n_r == fail_idx);
        n_r    <= n_r + 8'h01;
        cnt_r  <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/dsf_engine_tb.sv ====
// self-checking bench of the integrity status and flush engine
`timescale 1ns/100ps
`default_nettype none
module dsf_engine_tb
  import dsf_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        fl_req, fl_keep, fl_ack, fl_err, cr_valid, irq;
  logic [63:0] fl_addr;
  logic [3:0]  delay = 4'h0;
  logic [7:0]  fail_idx = 8'hFF;
  logic        restart = 1'b0;
  logic [63:0] exp_addr = 64'h0;
  logic [63:0] exp_base = 64'h0;
  logic        exp_keep = 1'b0;
  logic [31:0] seed = 32'h1B;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cr_cnt = 0;
  int          lines = 0;

  always #5 ref_clk = ~ref_clk;

  dsf_engine i_dut (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fl_req(fl_req), .fl_addr(fl_addr),
    .fl_keep(fl_keep), .fl_ack(fl_ack), .fl_err(fl_err),
    .cr_valid(cr_valid), .irq(irq));
  dsf_cache_model i_cache (
    .ref_clk(ref_clk), .srst(srst), .fl_req(fl_req), .fl_ack(fl_ack),
    .fl_err(fl_err), .delay(delay), .fail_idx(fail_idx),
    .restart(restart));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (cr_valid) cr_cnt <= cr_cnt + 1;
    if (restart) begin
      exp_addr <= exp_base;
      lines    <= 0;
    end else if (!srst && ce && fl_req && fl_ack) begin
      check(fl_addr, exp_addr);
      check(64'(fl_keep), 64'(exp_keep));
      exp_addr <= exp_addr + LINE_B;
      lines <= lines + 1;
    end
  end

  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [7:0] dif_exp(input logic [31:0] fl,
      input logic [31:0] ap, input logic [31:0] rf, input logic [15:0] gd);
    logic at1, rf1, all1, esc;
    logic [7:0] c;
    at1 = (ap[31:16] == 16'hFFFF);
    rf1 = (rf == 32'hFFFF_FFFF);
    all1 = at1 && rf1 && (gd == 16'hFFFF);
    esc = (fl[1] && all1) || (fl[2] && at1) || (fl[3] && at1 && rf1);
    c = 8'h00;
    c[0] = !esc && !fl[8] && fl[10];
    c[1] = !esc && (ap[15:0] != 16'hFFFF) && fl[11];
    c[2] = !esc && !fl[9] && fl[12];
    c[3] = fl[1] && fl[0] && all1;
    return c;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_cr(input int c0);
    int i;
    for (i = 0; i < 400 && cr_cnt == c0; i++) @(posedge ref_clk);
    if (cr_cnt == c0) begin
      miscompares++;
      print_verdict();
    end
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic run_op(input logic [7:0] op, input logic kp,
                        input logic pk);
    int c0;
    logic [31:0] d;
    wr(A_OPFL, {op, 15'h0000, kp, 8'h00});
    restart <= 1'b1;
    c0 = cr_cnt;
    wr(A_CTRL, 32'h0000_0001);
    restart <= 1'b0;
    if (pk) begin
      rd(A_STAT, d);
      check(64'(d[0]), 64'h1);
      wr(A_DSTL, 32'hDEAD_BEE0);
      ce <= 1'b0;
      repeat (6) @(posedge ref_clk);
      ce <= 1'b1;
    end
    wait_cr(c0);
  endtask

  task automatic flush(input logic [63:0] dst, input logic [31:0] sz,
                       input logic kp, input logic [7:0] fi, input logic pk);
    logic [63:0] lf;
    logic [31:0] d, e;
    int nl;
    nl = (sz == 32'h0) ? 0 :
         int'((dst + 64'(sz) - 64'h1) >> 6) - int'(dst >> 6) + 1;
    lf = {dst[63:6], 6'h00} + 64'(fi) * LINE_B;
    wr(A_DSTL, dst[31:0]);
    wr(A_DSTH, dst[63:32]);
    wr(A_SIZE, sz);
    fail_idx <= fi;
    exp_base <= {dst[63:6], 6'h00};
    exp_keep <= kp;
    run_op(OP_FLUSH, kp, pk);
    rd(A_CR0, d);
    rd(A_CR1, e);
    if (int'(fi) < nl) begin
      check(64'(lines), 64'(int'(fi) + 1));
      check(64'(d[7:0]), 64'(ST_FAULT));
      check(64'(e), (fi == 8'h00) ? 64'h0 : lf - dst);
      rd(A_CR2, d);
      rd(A_CR3, e);
      check({e, d}, lf);
    end else begin
      check(64'(lines), 64'(nl));
      check(64'(d[7:0]), 64'(ST_OK));
      check(64'(e), 64'(sz));
    end
    rd(A_DSTL, d);
    check(64'(d), 64'(dst[31:0]));
  endtask

  task automatic dif_op(input logic [7:0] op, input logic [31:0] fl,
      input logic [31:0] ap, input logic [31:0] rf, input logic [15:0] gd);
    logic [31:0] d;
    logic [7:0] c;
    logic [15:0] x;
    c = dif_exp(fl, ap, rf, gd);
    x = (c != 8'h00) ? {c, ST_DIFERR} : {8'h00, ST_OK};
    wr(A_DIFC, fl);
    wr(A_APP, ap);
    wr(A_REF, rf);
    wr(A_GRD, {16'h0000, gd});
    run_op(op, 1'b0, 1'b0);
    rd(A_CR0, d);
    check(64'(d[15:0]), 64'(x));
    rd(A_STAT, d);
    check(64'(d[15:0]), 64'({c, 8'h00}));
  endtask

  initial begin
    logic [31:0] r, a, d;
    int k;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (k = 0; k < 17; k++) begin
      rd(8'(k * 4), d);
      check(64'(d), 64'(RST_W));
    end
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h44, d);
    check(64'(d), 64'h0);
    dif_op(OP_CHECK, 32'h0000_1C03, 32'hFFFF_0000, 32'hFFFF_FFFF, 16'hFFFF);
    dif_op(OP_UPDATE, 32'h0000_1C00, 32'h1234_0000, 32'h0, 16'h0);
    dif_op(OP_STRIP, 32'h0000_1C04, 32'hFFFF_0000, 32'h0, 16'h0);
    dif_op(OP_CHECK, 32'h0000_1C08, 32'hFFFF_0000, 32'hFFFF_FFFF, 16'h0);
    dif_op(OP_CHECK, 32'h0000_1F00, 32'h0000_0000, 32'h0, 16'h0);
    for (k = 0; k < 40; k++) begin
      r = nxt();
      a = nxt();
      d = nxt();
      if (r[0]) a[31:16] = 16'hFFFF;
      if (r[1]) d = 32'hFFFF_FFFF;
      if (r[3]) a[15:0] = 16'hFFFF;
      dif_op(OP_CHECK + 8'(k % 3), {19'h0, r[20:8]}, a, d,
             r[2] ? 16'hFFFF : r[31:16]);
    end
    run_op(8'h55, 1'b0, 1'b0);
    rd(A_CR0, d);
    check(64'(d[7:0]), 64'(ST_BADOP));
    wr(A_IMR, 32'h0000_0001);
    flush(64'h3C, 32'h8, 1'b0, 8'hFF, 1'b0);
    check(64'(irq), 64'h1);
    rd(A_ISR, d);
    check(64'(d[0]), 64'h1);
    wr(A_ISR, 32'h0000_0007);
    repeat (2) @(posedge ref_clk);
    check(64'(irq), 64'h0);
    wr(A_IMR, 32'h0000_0000);
    flush(64'h1000, 32'h40, 1'b1, 8'hFF, 1'b0);
    check(64'(irq), 64'h0);
    flush(64'h1001, 32'h40, 1'b0, 8'hFF, 1'b0);
    flush(64'h80, 32'h0, 1'b0, 8'hFF, 1'b0);
    flush(64'h2010, 32'h12C, 1'b1, 8'h02, 1'b0);
    flush(64'h2010, 32'h12C, 1'b0, 8'h00, 1'b0);
    delay <= 4'h8;
    flush(64'h4000, 32'hC8, 1'b1, 8'hFF, 1'b1);
    for (k = 0; k < 12; k++) begin
      r = nxt();
      a = nxt();
      delay <= r[3:0];
      flush({16'h0000, a[15:0], a}, r & 32'h3FF, r[4], 8'hFF, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
